// File: inc/idpb_pkg.sv
package idpb_pkg;

  // Word addresses inside the 256-word block
  localparam logic [7:0] IDPB_W_CONFIG = 8'h00;
  localparam logic [7:0] IDPB_W_DEF_CYL = 8'h01;
  localparam logic [7:0] IDPB_W_DEF_HEADS = 8'h03;
  localparam logic [7:0] IDPB_W_UNF_TRACK = 8'h04;
  localparam logic [7:0] IDPB_W_UNF_SECT = 8'h05;
  localparam logic [7:0] IDPB_W_DEF_SPT = 8'h06;
  localparam logic [7:0] IDPB_W_TOTAL_MSW = 8'h07;
  localparam logic [7:0] IDPB_W_TOTAL_LSW = 8'h08;
  localparam logic [7:0] IDPB_W_SERIAL_LO = 8'h0A;
  localparam logic [7:0] IDPB_W_SERIAL_HI = 8'h13;
  localparam logic [7:0] IDPB_W_BUF_TYPE = 8'h14;
  localparam logic [7:0] IDPB_W_BUF_SIZE = 8'h15;
  localparam logic [7:0] IDPB_W_ECC = 8'h16;
  localparam logic [7:0] IDPB_W_FW_LO = 8'h17;
  localparam logic [7:0] IDPB_W_FW_HI = 8'h1A;
  localparam logic [7:0] IDPB_W_MODEL_LO = 8'h1B;
  localparam logic [7:0] IDPB_W_MODEL_HI = 8'h2E;
  localparam logic [7:0] IDPB_W_MAX_MULT = 8'h2F;
  localparam logic [7:0] IDPB_W_DWORD = 8'h30;
  localparam logic [7:0] IDPB_W_CAPS = 8'h31;
  localparam logic [7:0] IDPB_W_PIO_MODE = 8'h33;
  localparam logic [7:0] IDPB_W_XLATE_VALID = 8'h35;
  localparam logic [7:0] IDPB_W_CUR_CYL = 8'h36;
  localparam logic [7:0] IDPB_W_CUR_HEADS = 8'h37;
  localparam logic [7:0] IDPB_W_CUR_SPT = 8'h38;
  localparam logic [7:0] IDPB_W_CAP_LSW = 8'h39;
  localparam logic [7:0] IDPB_W_CAP_MSW = 8'h3A;
  localparam logic [7:0] IDPB_W_MULT_SET = 8'h3B;
  localparam logic [7:0] IDPB_W_LBA_LSW = 8'h3C;
  localparam logic [7:0] IDPB_W_LBA_MSW = 8'h3D;
  localparam logic [7:0] IDPB_W_SECURITY = 8'h80;
  localparam logic [7:0] IDPB_W_POWER = 8'hA0;
  localparam logic [7:0] IDPB_W_LAST = 8'hFF;

  // Fixed field values
  localparam logic [15:0] IDPB_ECC_COUNT = 16'h0004;
  localparam logic [15:0] IDPB_TRANS_VALID = 16'h0001;
  localparam logic [15:0] IDPB_DWORD_NONE = 16'h0000;
  localparam logic [7:0] IDPB_MULT_VALID = 8'h01;
  localparam logic [7:0] IDPB_MULT_RESET = 8'h00;
  localparam logic [7:0] IDPB_SPACE = 8'h20;

  // Buffer type codes
  localparam logic [15:0] IDPB_BUF_UNSPEC = 16'h0000;
  localparam logic [15:0] IDPB_BUF_SINGLE = 16'h0001;
  localparam logic [15:0] IDPB_BUF_DUAL = 16'h0002;
  localparam logic [15:0] IDPB_BUF_DUAL_CACHE = 16'h0003;

  // Bit positions
  localparam int IDPB_CAP_STANDBY = 13;
  localparam int IDPB_CAP_IORDY = 11;
  localparam int IDPB_CAP_LBA = 9;
  localparam int IDPB_CAP_DMA = 8;
  localparam int IDPB_SEC_LEVEL = 8;
  localparam int IDPB_SEC_EXPIRE = 4;
  localparam int IDPB_SEC_FREEZE = 3;
  localparam int IDPB_SEC_LOCK = 2;
  localparam int IDPB_SEC_ENABLE = 1;
  localparam int IDPB_SEC_SUPPORT = 0;
  localparam int IDPB_PWR_VALID = 15;
  localparam int IDPB_PWR_WORD_RESERVED_BIT = 14;
  localparam int IDPB_PWR_NO_L1 = 13;
  localparam int IDPB_PWR_L1_DIS = 12;

  // Register offsets (byte addresses)
  localparam logic [7:0] IDPB_R_CTRL = 8'h00;
  localparam logic [7:0] IDPB_R_STATUS = 8'h04;
  localparam logic [7:0] IDPB_R_DATA = 8'h08;
  localparam logic [7:0] IDPB_R_SETMULT = 8'h0C;
  localparam logic [7:0] IDPB_R_SECURITY = 8'h10;
  localparam logic [7:0] IDPB_R_GEOM = 8'h14;
  localparam logic [7:0] IDPB_R_CUR_CYL = 8'h18;

  // Reset values
  localparam logic [15:0] IDPB_CUR_CYL_RST = 16'h0000;
  localparam logic [7:0] IDPB_CUR_HEADS_RST = 8'h00;
  localparam logic [7:0] IDPB_CUR_SPT_RST = 8'h00;

  // APB request and answer
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } idpb_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } idpb_apb_rsp_t;

  // Live security state
  typedef struct packed {
    logic level_max;
    logic expired;
    logic frozen;
    logic locked;
    logic enabled;
  } idpb_sec_t;

endpackage : idpb_pkg

// File: design/idpb_block.sv
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Functional notes
// R1: Buffer type word reports 0, 1, 2 or 3 per buffer kind.
// R2: Buffer size word counts 512-byte units.
// R3: Serial string right-aligned, leading positions filled with spaces.
// R4: Model string left-aligned, trailing positions filled with spaces.
// R5: Total sectors equals first out-of-range linear block address.
// R6: Report maximum sectors per interrupt for multi-sector transfers.
// R7: Double-word field says 32-bit transfers unsupported.
// R8: Capability bit 13 set when idle timer behaves as defined.
// R9: Capability bit 11 set when IORDY definitely supported.
// R10: Capability bit 9 always set, linear addressing supported.
// R11: Capability bit 8 kept zero, no DMA.
// R12: Translation-valid word is 0001h, words 54 to 58 valid.
// R13: Current capacity is cylinders times heads times sectors per track.
// R14: Multiple-setting odd byte is always 01h, even byte holds count.
// R15: Even byte resets to 00h, then follows last set-multiple value.
// R16: Security level bit one means maximum, zero means high.
// R17: Expire bit set when attempts run out, sticky until reset.
// R18: Separate frozen, locked and enabled bits in security word.
// R19: Security word bit 0 shows feature set support.
// R20: Power word bit 15 valid flag, bit 14 always zero.
// R21: Power bits 13 and 12 show missing or disabled level-1 commands.
// R22: Maximum supply current in mA in power word bits 11..0.
// R23: Block leaves word by word like a single-sector read.
// R24: Every reserved bit and word reads as zero.
// R25: Word 22 reads 0004h, ECC byte count.
// R26: Total sectors high half in word 7, low half in word 8.
// R27: Fixed strings and geometry are parameters, live state sampled at read.
module idpb_block
  import idpb_pkg::*;
#(
  parameter logic [159:0] SERIAL = {{12{8'h20}}, 64'h3132_3334_3536_3738},
  parameter logic [63:0] FW_REV = "REV 1.00",
  parameter logic [319:0] MODEL = {"STORAGE CARD", {28{8'h20}}},
  parameter logic [15:0] CONFIG_WORD = 16'h1234, // Arbitrary value
  parameter logic [15:0] DEF_CYL = 16'h0100,
  parameter logic [15:0] DEF_HEADS = 16'h0004,
  parameter logic [15:0] UNF_TRACK = 16'h0000,
  parameter logic [15:0] UNF_SECT = 16'h0240,
  parameter logic [15:0] DEF_SPT = 16'h0020,
  parameter logic [15:0] BUF_TYPE = 16'h0001,
  parameter logic [15:0] BUF_UNITS = 16'h0001,
  parameter logic [15:0] MAX_MULT = 16'h0001,
  parameter logic [7:0] PIO_MODE = 8'h00,
  parameter logic STANDBY_DEFINED = 1'b1,
  parameter logic IORDY_SURE = 1'b1,
  parameter logic SEC_SUPPORTED = 1'b1,
  parameter logic PWR_DESC_VALID = 1'b1,
  parameter logic PWR_NO_L1 = 1'b0,
  parameter logic [11:0] MAX_CURRENT_MA = 12'h064
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // APB slave
  input wire idpb_apb_req_t apb_req,
  output idpb_apb_rsp_t apb_rsp,
  // Data word port
  output logic [15:0] word_data,
  output logic word_valid,
  output logic block_done
);

  ////////////////////////////////////////////////////////////////////////////
  // Fixed values

  localparam logic [31:0] TOTAL_SECT = 32'(DEF_CYL) * 32'(DEF_HEADS) * 32'(DEF_SPT);

  typedef enum logic [1:0] {
    IDPB_IDLE = 2'b00,
    IDPB_SEND = 2'b01
  } idpb_state_t;

  typedef struct packed {
    idpb_state_t st;
    logic [7:0] idx;
    logic [7:0] mult_cnt;
    idpb_sec_t sec;
    logic l1_disabled;
    logic [15:0] cur_cyl;
    logic [7:0] cur_heads;
    logic [7:0] cur_spt;
    logic [31:0] cur_cap;
    logic [15:0] word;
    logic wvalid;
    logic done;
    idpb_apb_rsp_t rsp;
  } idpb_regs_t;

  idpb_regs_t s_q;
  idpb_regs_t s_d;
  logic [15:0] word_w;
  logic [7:0] sidx;
  logic [7:0] midx;
  logic [7:0] fidx;

  ////////////////////////////////////////////////////////////////////////////
  // Word selection

  // Byte pairing of string words, first character high
  always_comb begin
    sidx = 8'(s_q.idx - IDPB_W_SERIAL_LO);
    midx = 8'(s_q.idx - IDPB_W_MODEL_LO);
    fidx = 8'(s_q.idx - IDPB_W_FW_LO);
    word_w = 16'h0000; // see R24
    if (s_q.idx >= IDPB_W_SERIAL_LO && s_q.idx <= IDPB_W_SERIAL_HI) begin
      word_w = SERIAL[159 - 16 * sidx -: 16]; // see R3
    end else if (s_q.idx >= IDPB_W_FW_LO && s_q.idx <= IDPB_W_FW_HI) begin
      word_w = FW_REV[63 - 16 * fidx -: 16];
    end else if (s_q.idx >= IDPB_W_MODEL_LO && s_q.idx <= IDPB_W_MODEL_HI) begin
      word_w = MODEL[319 - 16 * midx -: 16]; // see R4
    end else begin
      unique case (s_q.idx)
        IDPB_W_CONFIG: word_w = CONFIG_WORD;
        IDPB_W_DEF_CYL: word_w = DEF_CYL;
        IDPB_W_DEF_HEADS: word_w = {8'h00, DEF_HEADS[7:0]};
        IDPB_W_UNF_TRACK: word_w = UNF_TRACK;
        IDPB_W_UNF_SECT: word_w = UNF_SECT;
        IDPB_W_DEF_SPT: word_w = DEF_SPT;
        IDPB_W_TOTAL_MSW: word_w = TOTAL_SECT[31:16]; // see R5, R26
        IDPB_W_TOTAL_LSW: word_w = TOTAL_SECT[15:0]; // see R26
        IDPB_W_BUF_TYPE: word_w = BUF_TYPE; // see R1
        IDPB_W_BUF_SIZE: word_w = BUF_UNITS; // see R2
        IDPB_W_ECC: word_w = IDPB_ECC_COUNT; // see R25
        IDPB_W_MAX_MULT: word_w = MAX_MULT; // see R6
        IDPB_W_DWORD: word_w = IDPB_DWORD_NONE; // see R7
        IDPB_W_CAPS: begin
          word_w[IDPB_CAP_STANDBY] = STANDBY_DEFINED; // see R8
          word_w[IDPB_CAP_IORDY] = IORDY_SURE; // see R9
          word_w[IDPB_CAP_LBA] = 1'b1; // see R10
          word_w[IDPB_CAP_DMA] = 1'b0; // see R11
        end
        IDPB_W_PIO_MODE: word_w = {PIO_MODE, 8'h00};
        IDPB_W_XLATE_VALID: word_w = IDPB_TRANS_VALID; // see R12
        IDPB_W_CUR_CYL: word_w = s_q.cur_cyl; // see R27
        IDPB_W_CUR_HEADS: word_w = {8'h00, s_q.cur_heads};
        IDPB_W_CUR_SPT: word_w = {8'h00, s_q.cur_spt};
        IDPB_W_CAP_LSW: word_w = s_q.cur_cap[15:0]; // see R13
        IDPB_W_CAP_MSW: word_w = s_q.cur_cap[31:16];
        IDPB_W_MULT_SET: word_w = {IDPB_MULT_VALID, s_q.mult_cnt}; // see R14
        IDPB_W_LBA_LSW: word_w = TOTAL_SECT[15:0];
        IDPB_W_LBA_MSW: word_w = TOTAL_SECT[31:16];
        IDPB_W_SECURITY: begin
          word_w[IDPB_SEC_LEVEL] = s_q.sec.level_max; // see R16
          word_w[IDPB_SEC_EXPIRE] = s_q.sec.expired; // see R17
          word_w[IDPB_SEC_FREEZE] = s_q.sec.frozen; // see R18
          word_w[IDPB_SEC_LOCK] = s_q.sec.locked; // see R18
          word_w[IDPB_SEC_ENABLE] = s_q.sec.enabled; // see R18
          word_w[IDPB_SEC_SUPPORT] = SEC_SUPPORTED; // see R19
        end
        IDPB_W_POWER: begin
          word_w[IDPB_PWR_VALID] = PWR_DESC_VALID; // see R20
          word_w[IDPB_PWR_WORD_RESERVED_BIT] = 1'b0; // see R20
          word_w[IDPB_PWR_NO_L1] = PWR_NO_L1; // see R21
          word_w[IDPB_PWR_L1_DIS] = s_q.l1_disabled; // see R21
          word_w[11:0] = MAX_CURRENT_MA; // see R22
        end
        default: word_w = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Bus decode, live state update and word stream
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.rsp.pready = 1'b0;
    s_d.rsp.pslverr = 1'b0;
    s_d.rsp.prdata = 32'h0000_0000;
    s_d.cur_cap = 32'(s_q.cur_cyl) * 32'(s_q.cur_heads) * 32'(s_q.cur_spt); // see R13
    if (apb_req.psel && apb_req.penable && !s_q.rsp.pready) begin
      s_d.rsp.pready = 1'b1;
      unique case (apb_req.paddr)
        IDPB_R_CTRL: begin
          if (apb_req.pwrite && apb_req.pwdata[0] && s_q.st == IDPB_IDLE) begin
            s_d.st = IDPB_SEND; // see R23
            s_d.idx = 8'h00;
            s_d.wvalid = 1'b0;
          end
        end
        IDPB_R_STATUS: s_d.rsp.prdata = {30'h0, s_q.wvalid, s_q.st == IDPB_SEND};
        IDPB_R_DATA: begin
          if (!apb_req.pwrite && s_q.wvalid) begin
            s_d.rsp.prdata = {16'h0000, s_q.word};
            s_d.wvalid = 1'b0;
          end
        end
        IDPB_R_SETMULT: begin
          if (apb_req.pwrite) begin
            s_d.mult_cnt = apb_req.pwdata[7:0]; // see R15
          end else begin
            s_d.rsp.prdata = {24'h0, s_q.mult_cnt};
          end
        end
        IDPB_R_SECURITY: begin
          if (apb_req.pwrite) begin
            s_d.sec = apb_req.pwdata[4:0];
            s_d.sec.expired = s_q.sec.expired | apb_req.pwdata[3]; // see R17
            s_d.l1_disabled = apb_req.pwdata[5];
          end else begin
            s_d.rsp.prdata = {26'h0, s_q.l1_disabled, s_q.sec};
          end
        end
        IDPB_R_GEOM: begin
          if (apb_req.pwrite) begin
            s_d.cur_heads = apb_req.pwdata[7:0];
            s_d.cur_spt = apb_req.pwdata[15:8];
          end else begin
            s_d.rsp.prdata = {16'h0, s_q.cur_spt, s_q.cur_heads};
          end
        end
        IDPB_R_CUR_CYL: begin
          if (apb_req.pwrite) begin
            s_d.cur_cyl = apb_req.pwdata[15:0];
          end else begin
            s_d.rsp.prdata = {16'h0, s_q.cur_cyl};
          end
        end
        default: s_d.rsp.pslverr = 1'b1;
      endcase
    end
    // Present the next word once the previous one is taken
    if (s_q.st == IDPB_SEND && !s_q.wvalid) begin
      s_d.word = word_w; // see R23, R27
      s_d.wvalid = 1'b1;
      s_d.idx = 8'(s_q.idx + 8'h01);
      if (s_q.idx == IDPB_W_LAST) begin
        s_d.st = IDPB_IDLE;
        s_d.done = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // All state in one register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= IDPB_IDLE;
      s_q.mult_cnt <= IDPB_MULT_RESET; // see R15
      s_q.cur_cyl <= IDPB_CUR_CYL_RST;
      s_q.cur_heads <= IDPB_CUR_HEADS_RST;
      s_q.cur_spt <= IDPB_CUR_SPT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_rsp = s_q.rsp;
  assign word_data = s_q.word;
  assign word_valid = s_q.wvalid;
  assign block_done = s_q.done;

endmodule : idpb_block

// File: sim/idpb_checker.sv
`timescale 1ns/1ps
module idpb_checker
  import idpb_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Watched ports
  input wire idpb_apb_req_t apb_req,
  input wire idpb_apb_rsp_t apb_rsp,
  input wire logic [15:0] word_data,
  input wire logic word_valid,
  input wire logic block_done
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic wv_q;
  logic [7:0] idx_q;
  logic load;
  // New word appears on rising valid
  assign load = word_valid & ~wv_q;
  // Index of the word now loaded
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wv_q <= 1'b0;
      idx_q <= 8'h00;
    end else begin
      wv_q <= word_valid;
      idx_q <= idx_q + {7'h00, load};
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_access;
    apb_req.psel && apb_req.penable && !apb_rsp.pready;
  endsequence
  sequence s_at(logic [7:0] w);
    load && idx_q == w;
  endsequence
  property p_ready_wait;
    s_access |=> apb_rsp.pready;
  endproperty
  property p_ready_pulse;
    apb_rsp.pready |=> !apb_rsp.pready;
  endproperty
  property p_valid_hold;
    word_valid && !(apb_req.psel && apb_req.paddr == IDPB_R_DATA) |=> word_valid;
  endproperty
  property p_done;
    block_done |-> s_at(8'hFF);
  endproperty
  property p_ecc;
    s_at(IDPB_W_ECC) |-> word_data == IDPB_ECC_COUNT;
  endproperty
  property p_caps;
    s_at(IDPB_W_CAPS) |-> word_data[9:8] == 2'h2 && word_data[7:0] == 8'h00;
  endproperty
  property p_trans;
    s_at(IDPB_W_XLATE_VALID) |-> word_data == IDPB_TRANS_VALID;
  endproperty
  property p_mult;
    s_at(IDPB_W_MULT_SET) |-> word_data[15:8] == IDPB_MULT_VALID;
  endproperty
  property p_reserved;
    load && (idx_q inside {[8'd62:8'd127], [8'd161:8'd255]}) |-> word_data == 16'h0000;
  endproperty
  property p_power;
    s_at(IDPB_W_POWER) |-> !word_data[IDPB_PWR_WORD_RESERVED_BIT];
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("no answer one cycle after access");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  a_valid_hold: assert property (p_valid_hold) else $error("word dropped without a data read");
  a_done: assert property (p_done) else $error("done pulse not at last word");
  a_ecc: assert property (p_ecc) else $error("ecc count word wrong");
  a_caps: assert property (p_caps) else $error("capability word wrong");
  a_trans: assert property (p_trans) else $error("translation valid word wrong");
  a_mult: assert property (p_mult) else $error("multiple setting flag wrong");
  a_reserved: assert property (p_reserved) else $error("reserved word not zero");
  a_power: assert property (p_power) else $error("power reserved bit set");
endmodule : idpb_checker
bind idpb_block idpb_checker u_chk (.clock(clock), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .word_data(word_data), .word_valid(word_valid), .block_done(block_done));

// File: sim/idpb_host.sv
`timescale 1ns/1ps
module idpb_host
  import idpb_pkg::*;
(
  // Clock
  input wire logic clock,
  // APB master
  output idpb_apb_req_t apb_req,
  input wire idpb_apb_rsp_t apb_rsp
);
  // Bus idle from time zero
  initial apb_req = '0;
  // One transfer, held until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic ok);
    int n;
    n = 0;
    @(posedge clock);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    ok = n < 50;
    // Released lines show inverted values
    apb_req <= '{1'b0, 1'b0, ~w, ~a, ~d};
  endtask : xfer
endmodule : idpb_host

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import idpb_pkg::*;
  localparam logic [159:0] SER = {{18{8'h20}}, "A7"};
  localparam logic [319:0] MDL = {"CARD X", {34{8'h20}}};
  localparam logic [63:0] FW = "REV 1.00";
  localparam logic [15:0] DCYL = 16'h03E0;
  localparam logic [15:0] DHD = 16'h0010;
  localparam logic [15:0] DSPT = 16'h003F;
  localparam logic [31:0] TOT = 32'h000F_4200;
  logic clock = 1'b0;
  logic rst = 1'b1;
  idpb_apb_req_t apb_req;
  idpb_apb_rsp_t apb_rsp;
  logic [15:0] word_data;
  logic word_valid;
  logic block_done;
  int num_errors = 0;
  int checked = 0;
  logic [32:0] dones = '0;
  logic [15:0] lf = 16'h0005;
  logic [15:0] cyl = '0;
  logic [7:0] hd = '0;
  logic [7:0] spt = '0;
  logic [7:0] mult = '0;
  logic [5:0] sec = '0;
  logic [32:0] exp_q[$];
  string nm_q[$];
  always #2.5 clock = ~clock;
  idpb_block #(.SERIAL(SER), .MODEL(MDL), .DEF_CYL(DCYL), .DEF_HEADS(DHD), .DEF_SPT(DSPT),
    .BUF_TYPE(16'h0003), .BUF_UNITS(16'h0008), .MAX_MULT(16'h0010), .STANDBY_DEFINED(1'b0),
    .PWR_NO_L1(1'b1)) DUT (.clock(clock), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .word_data(word_data), .word_valid(word_valid), .block_done(block_done));
  idpb_host host (.clock(clock), .apb_req(apb_req), .apb_rsp(apb_rsp));
  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  // Expected block word from parameters and live state
  function automatic logic [15:0] ew(input int i);
    logic [31:0] c;
    c = cyl * hd * spt;
    ew = 16'h0000;
    if (i >= 10 && i <= 19) ew = SER[16 * (19 - i) +: 16];
    if (i >= 23 && i <= 26) ew = FW[16 * (26 - i) +: 16];
    if (i >= 27 && i <= 46) ew = MDL[16 * (46 - i) +: 16];
    case (i)
      0: ew = 16'h1234;
      1: ew = DCYL;
      3: ew = DHD;
      5: ew = 16'h0240;
      6: ew = DSPT;
      7, 61: ew = TOT[31:16];
      8, 60: ew = TOT[15:0];
      20: ew = 16'h0003;
      21: ew = 16'h0008;
      22: ew = IDPB_ECC_COUNT;
      47: ew = 16'h0010;
      49: ew = 16'h0A00;
      53: ew = IDPB_TRANS_VALID;
      54: ew = cyl;
      55: ew = {8'h00, hd};
      56: ew = {8'h00, spt};
      57: ew = c[15:0];
      58: ew = c[31:16];
      59: ew = {IDPB_MULT_VALID, mult};
      128: ew = {7'h00, sec[4], 3'h0, sec[3:0], 1'b1};
      160: ew = {3'h5, sec[5], 12'h064};
      default: ;
    endcase
  endfunction : ew
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic summarize();
    // Reads never answered count as one mismatch in all
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("BAD pending reads expected 0 seen %0d", exp_q.size());
    end
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    host.xfer(w, a, d, ok);
    if (!ok) begin
      num_errors++;
      summarize();
    end
  endtask : bus
  task automatic rd(input string n, input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    nm_q.push_back(n);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd
  // Read answers against oldest expectation
  always @(posedge clock) begin
    if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1 && !apb_req.pwrite && exp_q.size() > 0) begin
      chk(nm_q.pop_front(), exp_q.pop_front(), {apb_rsp.pslverr, apb_rsp.prdata});
    end
    if (block_done === 1'b1) dones++;
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd("multiple reset", IDPB_R_SETMULT, 33'h0_0000_0000);
    rd("unmapped", 8'h1C, 33'h1_0000_0000);
    rd("empty data", IDPB_R_DATA, 33'h0_0000_0000);
    for (int p = 0; p < 2; p++) begin
      if (p == 1) begin
        lf = lfsr(lf);
        mult = lf[7:0];
        cyl = lfsr(lf);
        lf = lfsr(cyl);
        hd = lf[7:0];
        spt = lf[15:8];
        sec = lf[5:0] | 6'h08;
        bus(1'b1, IDPB_R_SETMULT, {24'h00_0000, mult});
        bus(1'b1, IDPB_R_GEOM, {16'h0000, spt, hd});
        bus(1'b1, IDPB_R_CUR_CYL, {16'h0000, cyl});
        bus(1'b1, IDPB_R_SECURITY, {26'h000_0000, sec});
        bus(1'b1, IDPB_R_SECURITY, {26'h000_0000, sec & 6'h37});
        rd("security", IDPB_R_SECURITY, {1'b0, 26'h000_0000, sec});
        rd("multiple", IDPB_R_SETMULT, {1'b0, 24'h00_0000, mult});
        rd("geometry", IDPB_R_GEOM, {1'b0, 16'h0000, spt, hd});
        rd("cylinders", IDPB_R_CUR_CYL, {1'b0, 16'h0000, cyl});
      end
      bus(1'b1, IDPB_R_CTRL, 32'h0000_0001);
      rd("status sending", IDPB_R_STATUS, 33'h0_0000_0003);
      for (int i = 0; i < 256; i++) begin
        rd($sformatf("word %0d", i), IDPB_R_DATA, {17'h0_0000, ew(i)});
      end
      rd("status idle", IDPB_R_STATUS, 33'h0_0000_0000);
    end
    @(posedge clock);
    chk("done pulses", 33'h0_0000_0002, dones);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd("security reset", IDPB_R_SECURITY, 33'h0_0000_0000);
    rd("multiple again", IDPB_R_SETMULT, 33'h0_0000_0000);
    @(posedge clock);
    summarize();
  end
endmodule : testbench
